// ### dpram_host_pkg.sv
// Package: constants and carriers for the dual-port memory port controller
package dpram_host_pkg;
   // Array geometry (8K x 18 variant)
   localparam int ADDR_W        = 13;
   localparam int DATA_W        = 18;
   localparam int LANE_W        = 9;
   localparam logic [ADDR_W-1:0] MBOX_RIGHT = 13'h1fff;   // Right port mailbox
   localparam logic [ADDR_W-1:0] MBOX_LEFT  = 13'h1ffe;   // Left port mailbox
   localparam int TOKEN_W       = 3;                      // Token latch index bits
   // Timing, in ns, and derived cycle counts at 100 MHz
   localparam int CLK_NS        = 10;
   localparam int ACCESS_NS     = 25;                     // Access delay after select
   localparam int FLOW_NS       = 35;                     // Port to port flow-through
   localparam int SETUP_NS      = 15;                     // Data setup before strobe rise
   localparam int BUSY_NS       = 20;                     // Contention input settle
   localparam int RECOVER_NS    = 10;                     // Deselect time between cycles
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc
   localparam int CNT_W         = 4;
   localparam logic [CNT_W-1:0] ACCESS_CYC  = CNT_W'(ns2cyc(ACCESS_NS));
   localparam logic [CNT_W-1:0] FLOW_CYC    = CNT_W'(ns2cyc(FLOW_NS));
   localparam logic [CNT_W-1:0] SETUP_CYC   = CNT_W'(ns2cyc(SETUP_NS));
   localparam logic [CNT_W-1:0] BUSY_CYC    = CNT_W'(ns2cyc(BUSY_NS));
   localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(ns2cyc(RECOVER_NS));
   // Request from the user side
   typedef struct packed {
      logic              write;                           // 1 write, 0 read
      logic              token;                           // Token latch, not memory
      logic [1:0]        lanes;                           // [1] upper, [0] lower
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;
   // Pins driven toward one device port
   typedef struct packed {
      logic              chip_sel_n;
      logic              token_latch_select_n;
      logic              rw;                              // 1 read, 0 write
      logic              out_drive_n;
      logic              upper_byte_sel_n;
      logic              lower_byte_sel_n;
      logic [ADDR_W-1:0] addr;
   } pins_t;
endpackage : dpram_host_pkg

// ### cycle_timer.sv
// Reloadable down counter for access phase timing
`timescale 1ns/1ns
module cycle_timer
   import dpram_host_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Control
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] value,
   // Status
   output logic                  done
);
   logic [CNT_W-1:0] count;                               // Cycles left

   // Reload wins over counting
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   // Expired when zero; kept free of load so a reload on done forms no loop
   assign done = (count == '0);
endmodule : cycle_timer

// ### dpram_port_host.sv
// Host controller driving one port of the dual-port memory
`timescale 1ns/1ns
module dpram_port_host
   import dpram_host_pkg::*;
#(
   parameter bit IS_LEFT = 1'b1                           // Port side this host drives
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // User request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire req_t              req,
   // User answer
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_busy,
   output logic                   mail_pending,
   // Device control pins
   output pins_t                  pins,
   // Device data pins
   input  wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0]      data_out,
   output logic [DATA_W-1:0]      data_oe,
   // Device flags
   input  wire logic              busy_n,
   input  wire logic              mail_irq_n
);
   typedef enum logic [4:0] {
      S_IDLE   = 5'b00001,
      S_SETTLE = 5'b00010,
      S_ACTIVE = 5'b00100,
      S_DONE   = 5'b01000,
      S_RECOV  = 5'b10000
   } state_t;

   state_t            state;                              // Cycle sequencer
   state_t            next_state;
   req_t              cur;                                // Latched request
   logic              t_load;                             // Timer reload
   logic [CNT_W-1:0]  t_value;                            // Timer reload value
   logic              t_done;                             // Timer expired
   logic              busy_seen;                          // Busy sampled in cycle
   logic [DATA_W-1:0] rd_word;                            // Read data from last selected cycle

   // Lane mask for the data drivers
   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
      return {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};
   endfunction : lane_mask

   // Own mailbox address for this side
   function automatic logic [ADDR_W-1:0] own_mbox(input bit left);
      return left ? MBOX_LEFT : MBOX_RIGHT;
   endfunction : own_mbox

   cycle_timer u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (t_load),
      .value   (t_value),
      .done    (t_done)
   );

   // Next state and timer reloads
   always_comb begin
      next_state = state;
      t_load     = 1'b0;
      t_value    = '0;
      case (state)
         S_IDLE: begin
            if (req_valid) begin
               next_state = S_SETTLE;
               t_load     = 1'b1;
               t_value    = BUSY_CYC;
            end
         end
         S_SETTLE: begin
            // Address up, selects still high, busy given time to settle
            if (t_done) begin
               next_state = S_ACTIVE;
               t_load     = 1'b1;
               // Reads wait the flow-through bound so cross-port writes are seen
               t_value    = cur.write ? SETUP_CYC : FLOW_CYC;
            end
         end
         S_ACTIVE: begin
            if (t_done) begin
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            next_state = S_RECOV;
            t_load     = 1'b1;
            t_value    = RECOVER_CYC;
         end
         S_RECOV: begin
            if (t_done) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Request capture
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else if (state == S_IDLE && req_valid) begin
         cur <= req;
      end
   end

   assign req_ready = (state == S_IDLE);

   // Control pins; strobes only in the active phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pins <= '{chip_sel_n: 1'b1, token_latch_select_n: 1'b1, rw: 1'b1,
                   out_drive_n: 1'b1, upper_byte_sel_n: 1'b1,
                   lower_byte_sel_n: 1'b1, addr: '0};
      end else if (next_state == S_SETTLE || next_state == S_ACTIVE) begin
         pins.addr <= (next_state == S_SETTLE && state == S_IDLE) ? req.addr : cur.addr;
         if (next_state == S_ACTIVE) begin
            // Memory select stays high during a token access
            pins.chip_sel_n           <= cur.token;
            pins.token_latch_select_n <= !cur.token;
            pins.rw                   <= !cur.write;
            pins.out_drive_n          <= cur.write;
            pins.upper_byte_sel_n     <= cur.token ? 1'b1 : !cur.lanes[1];
            pins.lower_byte_sel_n     <= cur.token ? 1'b1 : !cur.lanes[0];
         end
      end else begin
         // Release all selects: write commits on this rising edge
         pins.chip_sel_n           <= 1'b1;
         pins.token_latch_select_n <= 1'b1;
         pins.rw                   <= 1'b1;
         pins.out_drive_n          <= 1'b1;
         pins.upper_byte_sel_n     <= 1'b1;
         pins.lower_byte_sel_n     <= 1'b1;
      end
   end

   // Write data driven from the end of settle through the strobe rise for setup and hold
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= '0;
         data_oe  <= '0;
      end else if (state == S_SETTLE && t_done && cur.write) begin
         // Token writes carry the request in bit zero only
         data_out <= cur.token ? {{(DATA_W-1){1'b0}}, cur.wdata[0]} : cur.wdata;
         data_oe  <= cur.token ? {{(DATA_W-1){1'b0}}, 1'b1} : lane_mask(cur.lanes);
      end else if (state == S_RECOV || state == S_IDLE) begin
         data_oe  <= '0;
      end
   end

   // Busy sampled after settle; a lost write is reported
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_seen <= 1'b0;
      end else if (state == S_SETTLE && next_state == S_ACTIVE) begin
         busy_seen <= !busy_n && !cur.token;
      end else if (state == S_ACTIVE && !busy_n && !cur.token) begin
         busy_seen <= 1'b1;
      end
   end

   // Read data taken while selects are still low; released lines are not valid
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_word <= '0;
      end else if (state == S_ACTIVE && t_done) begin
         // Token read shows the latch on every line; bit zero taken
         rd_word <= cur.token ? {DATA_W{data_in[0]}} : data_in & lane_mask(cur.lanes);
      end
   end

   // Answer: read data, busy outcome, one-cycle valid
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
         rsp_busy  <= 1'b0;
      end else begin
         rsp_valid <= (state == S_DONE);
         if (state == S_DONE) begin
            rsp_busy <= busy_seen;
            // Writes answer with zero data
            rsp_data <= cur.write ? '0 : rd_word;
         end
      end
   end

   // Interrupt flag mirrored as active-high level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mail_pending <= 1'b0;
      end else begin
         mail_pending <= !mail_irq_n;
      end
   end

   // Sampling point is decoded from S_DONE, the cycle after data is captured at the strobe's end
   logic sampled_in_active;
   assign sampled_in_active = (state == S_DONE) && !cur.write;

   // Sequence: settle, then active within 1 to 8 cycles
   sequence s_settle_to_active;
      state == S_SETTLE ##[1:8] state == S_ACTIVE;
   endsequence

   a_idle_pins_off: assert property (@(posedge clk) disable iff (!reset_n)
      state == S_IDLE |-> pins.chip_sel_n && pins.token_latch_select_n)
      else $error("selects active while idle");
   a_token_csel_high: assert property (@(posedge clk) disable iff (!reset_n)
      !pins.token_latch_select_n |-> pins.chip_sel_n)
      else $error("memory select during token access");
   a_read_drive_on: assert property (@(posedge clk) disable iff (!reset_n)
      (!pins.chip_sel_n && pins.rw) |-> !pins.out_drive_n)
      else $error("read without output drive");
   a_write_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
      !pins.rw |-> pins.out_drive_n && data_oe != '0)
      else $error("write strobe without data driven");
   a_data_held_rise: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(pins.rw) |-> $stable(data_out) && data_oe != '0)
      else $error("data not held at strobe rise");
   a_settle_first: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state == S_SETTLE) |-> s_settle_to_active)
      else $error("settle phase not followed by access");
   a_token_bit0: assert property (@(posedge clk) disable iff (!reset_n)
      (!pins.token_latch_select_n && !pins.rw) |-> data_oe[DATA_W-1:1] == '0)
      else $error("token write drives above bit zero");
   a_lane_gate: assert property (@(posedge clk) disable iff (!reset_n)
      !pins.chip_sel_n && pins.upper_byte_sel_n |-> data_oe[DATA_W-1:LANE_W] == '0)
      else $error("upper lane driven while deselected");
   a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
      sampled_in_active |=> rsp_valid)
      else $error("read answer missing");
endmodule : dpram_port_host

// ### dpram_dev_model.sv
// Behavioural two-port memory device: array, mailboxes, contention flags, token latches
`timescale 1ns/1ns
module dpram_dev_model
   import dpram_host_pkg::*;
(
   // Clock and reset of the bench
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Pins of both hosts, index 0 left, 1 right
   input  wire pins_t             pins     [2],
   input  wire logic [DATA_W-1:0] host_out [2],
   input  wire logic [DATA_W-1:0] host_oe  [2],
   // Wire levels and flags toward the hosts
   output logic [DATA_W-1:0]      level    [2],
   output logic [1:0]             busy_n,
   output logic [1:0]             irq_n
);
   logic [DATA_W-1:0]  mem  [2**ADDR_W];  // Word array
   logic [DATA_W-1:0]  last [2];          // Last wire level, for released lines
   logic [DATA_W-1:0]  cap  [2];          // Data seen during a write
   logic [ADDR_W-1:0]  ad   [2];          // Address of the access
   logic [1:0]         ln   [2];          // Enabled lanes
   logic [TOKEN_W-1:0] ti   [2];          // Token index, low bits only
   logic [7:0]         treq [2];          // Pending token requests
   logic [1:0]         own  [8];          // Token owner: 0 none, 1 left, 2 right
   logic [1:0]         act, wr, tk, lost, irq, bz, bz_q;
   // Later arrival loses; a tie goes against the right port
   always_comb begin
      bz = 2'b00;
      if (!pins[0].chip_sel_n && !pins[1].chip_sel_n && pins[0].addr == pins[1].addr) begin
         bz = (act == 2'b01) ? 2'b10 : (act == 2'b10) ? 2'b01 : (act == 2'b11) ? bz_q : 2'b10;
      end
   end
   assign busy_n = ~bz;  // Primary mode drives the flags
   assign irq_n  = ~irq;
   // Read drive per port; a line nobody drives shows the inverse of its last level
   for (genvar p = 0; p < 2; p++) begin : side
      logic              rd;
      logic [DATA_W-1:0] dv, de;
      assign ti[p] = ad[p][TOKEN_W-1:0];
      assign rd = pins[p].rw && !pins[p].out_drive_n;  // Read plus drive
      assign dv = !pins[p].token_latch_select_n ?
                  {DATA_W{own[pins[p].addr[TOKEN_W-1:0]] != 2'(p + 1)}} :
                  mem[pins[p].addr];  // New data at once
      assign de = (rd && !pins[p].token_latch_select_n) ? '1 :
                  (rd && !pins[p].chip_sel_n) ?
                  {{LANE_W{!pins[p].upper_byte_sel_n}}, {LANE_W{!pins[p].lower_byte_sel_n}}} :
                  '0;  // Deselected lanes float
      assign level[p] = (host_oe[p] & host_out[p]) | (~host_oe[p] & ((de & dv) | (~de & ~last[p])));
   end
   // Accesses take effect when the select rises
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         act <= '0;
         lost <= '0;
         irq <= '0;
         bz_q <= '0;
         for (int p = 0; p < 2; p++) last[p] <= '0;
         for (int p = 0; p < 2; p++) treq[p] <= '0;
         for (int i = 0; i < 8; i++) own[i] <= 2'd0;
      end else begin
         bz_q <= bz;
         for (int p = 0; p < 2; p++) begin
            last[p] <= level[p];
            act[p] <= !pins[p].chip_sel_n || !pins[p].token_latch_select_n;
            if (!pins[p].chip_sel_n || !pins[p].token_latch_select_n) begin
               wr[p] <= !pins[p].rw;
               tk[p] <= !pins[p].token_latch_select_n;  // Memory select stays high
               ad[p] <= pins[p].addr;
               ln[p] <= {!pins[p].upper_byte_sel_n, !pins[p].lower_byte_sel_n};
               cap[p] <= level[p];
               lost[p] <= (act[p] & lost[p]) | bz[p];
            end else if (act[p]) begin
               // A losing write never lands
               if (wr[p] && !tk[p] && !lost[p]) begin
                  if (ln[p][1]) mem[ad[p]][DATA_W-1:LANE_W] <= cap[p][DATA_W-1:LANE_W];
                  if (ln[p][0]) mem[ad[p]][LANE_W-1:0] <= cap[p][LANE_W-1:0];
                  if (ad[p] == (p == 0 ? MBOX_RIGHT : MBOX_LEFT)) irq[1-p] <= 1'b1;
               end
               // Only an unbusy read of the own mailbox clears
               if (!wr[p] && !tk[p] && !lost[p] && ad[p] == (p == 0 ? MBOX_LEFT : MBOX_RIGHT)) irq[p] <= 1'b0;
               // Token write: bit zero requests or releases
               if (wr[p] && tk[p]) begin
                  treq[p][ti[p]] <= !cap[p][0];
                  if (!cap[p][0] && own[ti[p]] == 2'd0) own[ti[p]] <= 2'(p + 1);
                  if (cap[p][0] && own[ti[p]] == 2'(p + 1)) own[ti[p]] <= treq[1-p][ti[p]] ? 2'(2 - p) : 2'd0;
               end
            end
         end
      end
   end
endmodule : dpram_dev_model

// ### dual_port_ram_arbiter_mailbox_tb.sv
// Self-checking bench: two port hosts facing one device model
`timescale 1ns/1ns
module dual_port_ram_arbiter_mailbox_tb;
   import dpram_host_pkg::*;
   logic              clk, reset_n;
   logic [1:0]        req_valid, req_ready, rsp_valid, rsp_busy, mail_pending, busy_n, irq_n, gbz;
   req_t              req [2];
   pins_t             pins [2];
   logic [DATA_W-1:0] rsp_data [2], data_out [2], data_oe [2], level [2], got [2];
   logic [15:0]       seed;  // Random source state
   int                miscompares, total_checks;
   // One host per device port
   for (genvar g = 0; g < 2; g++) begin : port
      dpram_port_host #(.IS_LEFT(g == 0)) dpram_port_host_i (
         .clk(clk), .reset_n(reset_n), .req_valid(req_valid[g]), .req_ready(req_ready[g]),
         .req(req[g]), .rsp_valid(rsp_valid[g]), .rsp_data(rsp_data[g]), .rsp_busy(rsp_busy[g]),
         .mail_pending(mail_pending[g]), .pins(pins[g]), .data_in(level[g]),
         .data_out(data_out[g]), .data_oe(data_oe[g]), .busy_n(busy_n[g]), .mail_irq_n(irq_n[g]));
   end
   dpram_dev_model dpram_dev_model_i (
      .clk(clk), .reset_n(reset_n), .pins(pins), .host_out(data_out), .host_oe(data_oe),
      .level(level), .busy_n(busy_n), .irq_n(irq_n));
   always #5 clk = ~clk;
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction : rnd
   function automatic logic [DATA_W-1:0] lmask(input logic [1:0] l);
      return {{LANE_W{l[1]}}, {LANE_W{l[0]}}};
   endfunction : lmask
   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic chk_word(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_flag(input string nm, input logic e, input logic g);
      chk_word(nm, {17'h0, e}, {17'h0, g});
   endtask : chk_flag
   task automatic chk_pend(input int p, input logic e);
      repeat (3) @(negedge clk);
      chk_flag("mail pending", e, mail_pending[p]);
   endtask : chk_pend
   // One whole transfer on port p, driven at falling edges
   task automatic xfer(input int p, input logic w, input logic t, input logic [1:0] l,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(negedge clk);
      req[p] = '{write: w, token: t, lanes: l, addr: a, wdata: d};
      req_valid[p] = 1'b1;
      for (n = 0; n < 50 && req_ready[p] !== 1'b1; n++) @(negedge clk);
      if (n >= 50) begin
         miscompares++;
         close_out();
      end
      @(negedge clk);
      req_valid[p] = 1'b0;
      for (n = 0; n < 50 && rsp_valid[p] !== 1'b1; n++) @(negedge clk);
      if (n >= 50) begin
         miscompares++;
         close_out();
      end
      got[p] = rsp_data[p];
      gbz[p] = rsp_busy[p];
   endtask : xfer
   // Hang guard, far beyond the expected run
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   initial begin
      int p;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d1, d2;
      logic [1:0] l2, l3;
      clk = 1'b0;
      reset_n = 1'b0;
      req_valid = '0;
      req[0] = '0;
      req[1] = '0;
      seed = 16'h0060;
      miscompares = 0;
      total_checks = 0;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      // Full write, overwrite of one or both lanes, read on the other port; edge addresses first
      for (int i = 0; i < 24; i++) begin
         p = i % 2;
         a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1ffd : ADDR_W'(rnd() % 16'h1ffe);
         d1 = {2'(rnd()), rnd()};
         d2 = {2'(rnd()), rnd()};
         l2 = 2'(rnd() % 3 + 1);
         l3 = 2'(rnd() % 3 + 1);
         xfer(p, 1'b1, 1'b0, 2'b11, a, d1);
         xfer(p, 1'b1, 1'b0, l2, a, d2);
         xfer(1 - p, 1'b0, 1'b0, l3, a, '0);
         chk_word("cross read", ((d2 & lmask(l2)) | (d1 & ~lmask(l2))) & lmask(l3), got[1 - p]);
      end
      // Mailbox raise, foreign read, own read
      xfer(0, 1'b1, 1'b0, 2'b11, MBOX_RIGHT, 18'h2a5a5);
      chk_pend(1, 1'b1);
      xfer(0, 1'b0, 1'b0, 2'b11, MBOX_RIGHT, '0);
      chk_pend(1, 1'b1);
      xfer(1, 1'b0, 1'b0, 2'b11, MBOX_RIGHT, '0);
      chk_word("right mailbox", 18'h2a5a5, got[1]);
      chk_pend(1, 1'b0);
      xfer(1, 1'b1, 1'b0, 2'b11, MBOX_LEFT, 18'h1c3c3);
      chk_pend(0, 1'b1);
      // Left reads its mailbox one cycle late and loses
      fork
         xfer(1, 1'b0, 1'b0, 2'b11, MBOX_LEFT, '0);
         begin
            @(negedge clk);
            xfer(0, 1'b0, 1'b0, 2'b11, MBOX_LEFT, '0);
         end
      join
      chk_flag("left busy", 1'b1, gbz[0]);
      chk_pend(0, 1'b1);
      xfer(0, 1'b0, 1'b0, 2'b11, MBOX_LEFT, '0);
      chk_word("left mailbox", 18'h1c3c3, got[0]);
      chk_pend(0, 1'b0);
      // Right writes the left mailbox late and loses
      fork
         xfer(0, 1'b1, 1'b0, 2'b11, MBOX_LEFT, 18'h00111);
         begin
            @(negedge clk);
            xfer(1, 1'b1, 1'b0, 2'b11, MBOX_LEFT, 18'h3fefe);
         end
      join
      chk_flag("right busy", 1'b1, gbz[1]);
      chk_pend(0, 1'b0);
      xfer(1, 1'b0, 1'b0, 2'b11, MBOX_LEFT, '0);
      chk_word("winner data", 18'h00111, got[1]);
      // Same-cycle writes still give one winner
      fork
         xfer(0, 1'b1, 1'b0, 2'b11, 13'h0123, 18'h0aaaa);
         xfer(1, 1'b1, 1'b0, 2'b11, 13'h0123, 18'h15555);
      join
      chk_flag("one winner", 1'b1, gbz[0] ^ gbz[1]);
      xfer(0, 1'b0, 1'b0, 2'b11, 13'h0123, '0);
      chk_word("tie data", gbz[0] ? 18'h15555 : 18'h0aaaa, got[0]);
      // Every token latch: take, contend, hand over, release
      for (int i = 0; i < 8; i++) begin
         a = {10'(rnd()), 3'(i)};
         xfer(0, 1'b1, 1'b1, 2'b11, a, 18'h3fffe);
         xfer(1, 1'b1, 1'b1, 2'b11, ADDR_W'(i), 18'h00000);
         xfer(0, 1'b0, 1'b1, 2'b11, ADDR_W'(i), '0);
         chk_word("token left", '0, got[0]);
         xfer(1, 1'b0, 1'b1, 2'b11, a, '0);
         chk_word("token right", '1, got[1]);
         xfer(0, 1'b1, 1'b1, 2'b11, a, 18'h00001);
         xfer(1, 1'b0, 1'b1, 2'b11, ADDR_W'(i), '0);
         chk_word("token handover", '0, got[1]);
         xfer(1, 1'b1, 1'b1, 2'b11, ADDR_W'(i), 18'h3ffff);
      end
      close_out();
   end
endmodule : dual_port_ram_arbiter_mailbox_tb
